//--- wdc_pkg.sv
package wdc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WAKE_US = 100;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int REF_MS = 16;
  localparam int REF_ROWS = 1024;
  // window per row, rounded down so all rows fit in the period
  localparam int REF_INT_CYC = (REF_MS * 1000 * CLK_MHZ) / REF_ROWS;
  localparam int WAKE_REFS = 8;
  // strobe phase lengths in cycles (10 ns each)
  localparam int T_RP = 6;
  localparam int T_RAS = 8;
  localparam int T_CAS = 2;
  localparam int T_CSR = 1;
  localparam int T_OFF = 2;
  localparam int T_OEH = 2;
  localparam int T_RCD = 2;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 20;
  typedef enum logic [1:0] {
    WDC_OP_READ, WDC_OP_EARLY_WR, WDC_OP_RMW
  } wdc_op_t;
endpackage : wdc_pkg

//--- wdc_ctrl.sv
`timescale 1ns/1ns
module wdc_ctrl #(
  parameter int WAKE_CYCLES = wdc_pkg::WAKE_CYC,
  parameter int REF_INTERVAL = wdc_pkg::REF_INT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire wdc_pkg::wdc_op_t req_op,
  input wire logic [2*wdc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_bytes,
  input wire logic req_masked,
  input wire logic [wdc_pkg::DATA_W-1:0] req_mask,
  input wire logic [wdc_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [wdc_pkg::DATA_W-1:0] rsp_rdata,
  output logic mem_ready,
  output logic ras_n,
  output logic cas_n,
  output logic lower_byte_write_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic oe_n,
  output logic [wdc_pkg::ADDR_W-1:0] addr,
  output logic [wdc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [wdc_pkg::DATA_W-1:0] dq_in
);
  import wdc_pkg::*;

  typedef enum logic [3:0] {
    ST_WAKE, ST_IDLE, ST_PRE, ST_REF_CAS, ST_REF_RAS, ST_ROW, ST_COL,
    ST_LATE_WR, ST_DONE, ST_HIDE
  } wdc_state_t;

  // ---------------------------------------------------------------
  // input synchroniser for the data pins
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  wdc_state_t st_r, st_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [CNT_W-1:0] ref_r, ref_nxt;
  logic [3:0] wake_r, wake_nxt;
  logic ref_due_r, ref_due_nxt;
  logic awake_r, awake_nxt;
  logic go_r, go_nxt;
  wdc_op_t op_r, op_nxt;
  logic [2*ADDR_W-1:0] a_r, a_nxt;
  logic [1:0] be_r, be_nxt;
  logic msk_r, msk_nxt;
  logic [DATA_W-1:0] mask_r, mask_nxt, wd_r, wd_nxt;
  logic ras_r, ras_nxt, cas_r, cas_nxt, wel_r, wel_nxt, weh_r, weh_nxt;
  logic oe_r, oe_nxt, dqoe_r, dqoe_nxt, rdy_r, rdy_nxt, rv_r, rv_nxt;
  logic [ADDR_W-1:0] ad_r, ad_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction : cyc

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
    ref_nxt = (ref_r != '0) ? ref_r - 1'b1 : ref_r;
    ref_due_nxt = ref_due_r | (ref_r == '0);
    wake_nxt = wake_r;
    awake_nxt = awake_r;
    go_nxt = go_r;
    op_nxt = op_r;
    a_nxt = a_r;
    be_nxt = be_r;
    msk_nxt = msk_r;
    mask_nxt = mask_r;
    wd_nxt = wd_r;
    ras_nxt = ras_r;
    cas_nxt = cas_r;
    wel_nxt = wel_r;
    weh_nxt = weh_r;
    oe_nxt = oe_r;
    dqoe_nxt = dqoe_r;
    ad_nxt = ad_r;
    dq_nxt = dq_r;
    rd_nxt = rd_r;
    rv_nxt = 1'b0;
    rdy_nxt = 1'b0;
    if (ref_r == '0) begin
      ref_nxt = cyc(REF_INTERVAL - 1);
      // a window passed unserved: refresh overdue, wake again
      if (ref_due_r) begin
        awake_nxt = 1'b0;
        wake_nxt = 4'(WAKE_REFS);
      end
    end
    unique case (st_r)
      ST_WAKE: begin
        if (tmr_r == '0) begin
          st_nxt = ST_PRE;
          tmr_nxt = cyc(T_RP);
        end
      end
      ST_IDLE: begin
        rdy_nxt = awake_r && !ref_due_nxt && wake_r == '0;
        if (wake_r != '0 || ref_due_r) begin
          st_nxt = ST_PRE;
          tmr_nxt = cyc(T_RP);
        end else if (req_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          op_nxt = req_op;
          a_nxt = req_addr;
          be_nxt = req_bytes;
          msk_nxt = req_masked;
          mask_nxt = req_mask;
          go_nxt = 1'b1;
          wd_nxt = req_wdata;
          st_nxt = ST_PRE;
          tmr_nxt = cyc(T_RP);
        end
      end
      ST_PRE: begin
        // all strobes high: a fresh cycle never inherits old output
        ras_nxt = 1'b1;
        cas_nxt = 1'b1;
        wel_nxt = 1'b1;
        weh_nxt = 1'b1;
        oe_nxt = 1'b1;
        dqoe_nxt = 1'b0;
        if (tmr_r == '0) begin
          // a taken request owns this precharge; a due refresh waits
          if (!go_r) begin
            cas_nxt = 1'b0;
            st_nxt = ST_REF_CAS;
            tmr_nxt = cyc(T_CSR);
          end else begin
            ad_nxt = a_r[2*ADDR_W-1:ADDR_W];
            ras_nxt = 1'b0;
            // masked write selection sampled at row fall
            if (op_r != WDC_OP_READ && msk_r) begin
              wel_nxt = ~be_r[0];
              weh_nxt = ~be_r[1];
              dq_nxt = mask_r;
              dqoe_nxt = 1'b1;
            end
            st_nxt = ST_ROW;
            tmr_nxt = cyc(T_RCD);
          end
        end
      end
      ST_REF_CAS: begin
        if (tmr_r == '0) begin
          ras_nxt = 1'b0;
          st_nxt = ST_REF_RAS;
          tmr_nxt = cyc(T_RAS);
        end
      end
      ST_REF_RAS: begin
        if (tmr_r == '0) begin
          ras_nxt = 1'b1;
          cas_nxt = 1'b1;
          wel_nxt = 1'b1;
          weh_nxt = 1'b1;
          // a window ending in this cycle keeps its request
          ref_due_nxt = (ref_r == '0);
          if (wake_r != '0) begin
            wake_nxt = wake_r - 1'b1;
            if (wake_r == 4'h1) begin
              awake_nxt = 1'b1;
            end
          end
          st_nxt = ST_IDLE;
        end
      end
      ST_ROW: begin
        wel_nxt = 1'b1;
        weh_nxt = 1'b1;
        dqoe_nxt = 1'b0;
        if (tmr_r == '0) begin
          ad_nxt = a_r[ADDR_W-1:0];
          cas_nxt = 1'b0;
          if (op_r == WDC_OP_EARLY_WR) begin
            wel_nxt = ~be_r[0];
            weh_nxt = ~be_r[1];
            dq_nxt = wd_r;
            dqoe_nxt = 1'b1;
          end else begin
            oe_nxt = 1'b0;
          end
          st_nxt = ST_COL;
          tmr_nxt = cyc(T_CAS + T_RCD);
        end
      end
      ST_COL: begin
        if (tmr_r == '0) begin
          if (op_r == WDC_OP_EARLY_WR) begin
            st_nxt = ST_DONE;
            tmr_nxt = cyc(T_CAS);
          end else begin
            rd_nxt = dq_s2_r;
            oe_nxt = 1'b1;
            if (op_r == WDC_OP_RMW) begin
              st_nxt = ST_LATE_WR;
              tmr_nxt = cyc(T_OFF);
            end else begin
              rv_nxt = 1'b1;
              st_nxt = ST_DONE;
              tmr_nxt = cyc(T_CAS);
            end
          end
        end
      end
      ST_LATE_WR: begin
        if (tmr_r == '0 && !dqoe_r) begin
          // outputs are open now; only then drive write data
          dq_nxt = wd_r;
          dqoe_nxt = 1'b1;
          wel_nxt = ~be_r[0];
          weh_nxt = ~be_r[1];
          rv_nxt = 1'b1;
          st_nxt = ST_DONE;
          tmr_nxt = cyc(T_OEH);
        end
      end
      ST_DONE: begin
        if (tmr_r == '0) begin
          ras_nxt = 1'b1;
          dqoe_nxt = 1'b0;
          go_nxt = 1'b0;
          if (op_r == WDC_OP_EARLY_WR && ref_due_r) begin
            // hidden refresh: column and write stay low, enable high
            oe_nxt = 1'b1;
            st_nxt = ST_HIDE;
            tmr_nxt = cyc(T_RP);
          end else begin
            // column rises with the row strobe; enable stays high so outputs stay open
            cas_nxt = 1'b1;
            wel_nxt = 1'b1;
            weh_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_HIDE: begin
        if (tmr_r == '0) begin
          ras_nxt = 1'b0;
          st_nxt = ST_REF_RAS;
          tmr_nxt = cyc(T_RAS);
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= ST_WAKE;
      tmr_r <= '0;
      ref_r <= '0;
      ref_due_r <= 1'b0;
      wake_r <= 4'(WAKE_REFS);
      awake_r <= 1'b0;
      go_r <= 1'b0;
      op_r <= WDC_OP_READ;
      a_r <= '0;
      be_r <= '0;
      msk_r <= 1'b0;
      mask_r <= '0;
      wd_r <= '0;
      ras_r <= 1'b1;
      cas_r <= 1'b1;
      wel_r <= 1'b1;
      weh_r <= 1'b1;
      oe_r <= 1'b1;
      dqoe_r <= 1'b0;
      ad_r <= '0;
      dq_r <= '0;
      rd_r <= '0;
      rv_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= (st_r == ST_WAKE && !awake_r && tmr_r == '0 &&
                wake_r == 4'(WAKE_REFS) && ref_r == '0) ?
               cyc(WAKE_CYCLES) : tmr_nxt;
      ref_r <= ref_nxt;
      ref_due_r <= ref_due_nxt;
      wake_r <= wake_nxt;
      awake_r <= awake_nxt;
      go_r <= go_nxt;
      op_r <= op_nxt;
      a_r <= a_nxt;
      be_r <= be_nxt;
      msk_r <= msk_nxt;
      mask_r <= mask_nxt;
      wd_r <= wd_nxt;
      ras_r <= ras_nxt;
      cas_r <= cas_nxt;
      wel_r <= wel_nxt;
      weh_r <= weh_nxt;
      oe_r <= oe_nxt;
      dqoe_r <= dqoe_nxt;
      ad_r <= ad_nxt;
      dq_r <= dq_nxt;
      rd_r <= rd_nxt;
      rv_r <= rv_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign req_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_rdata = rd_r;
  assign mem_ready = awake_r;
  assign ras_n = ras_r;
  assign cas_n = cas_r;
  assign lower_byte_write_strobe_n = wel_r;
  assign upper_byte_write_strobe_n = weh_r;
  assign oe_n = oe_r;
  assign addr = ad_r;
  assign dq_out = dq_r;
  assign dq_oe = dqoe_r;
endmodule : wdc_ctrl

//--- wdc_ctrl_checker.sv
`timescale 1ns/1ns
module wdc_ctrl_checker
  import wdc_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int REF_INTERVAL = REF_INT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic mem_ready,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic oe_n,
  input wire logic dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic ras_q, wr_n, row_fall;
  int cyc_r, refs_r, gap_r;
  assign wr_n = lower_byte_write_strobe_n & upper_byte_write_strobe_n;
  assign row_fall = ras_q & ~ras_n;
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ras_q <= 1'b1;
      cyc_r <= 0;
      refs_r <= 0;
      gap_r <= 0;
    end else begin
      ras_q <= ras_n;
      if (cyc_r < WAKE_CYCLES) cyc_r <= cyc_r + 1;
      if (row_fall && !cas_n) begin
        refs_r <= refs_r + 1;
        gap_r <= 0;
      end else gap_r <= gap_r + 1;
    end
  end
  wake_wait_a: assert property (row_fall |-> cyc_r >= WAKE_CYCLES)
    else $error("row strobe before wake pause");
  ready_refs_a: assert property ($rose(mem_ready) |-> refs_r >= WAKE_REFS)
    else $error("ready before eight refreshes");
  ready_waked_a: assert property (req_ready |-> mem_ready)
    else $error("request offered while waking");
  // hidden refresh keeps the column strobe low on purpose
  cas_pulse_a: assert property (row_fall && (cas_n || wr_n)
    |-> $past(cas_n, 3))
    else $error("column strobe not high before row strobe");
  hidden_keep_a: assert property (row_fall && !cas_n && !wr_n
    |-> oe_n && !dq_oe)
    else $error("hidden refresh without enable high");
  refresh_quiet_a: assert property (row_fall && !cas_n |-> !dq_oe)
    else $error("data driven in refresh");
  mask_drive_a: assert property (row_fall && cas_n && !wr_n |-> dq_oe)
    else $error("mask not driven at row strobe");
  early_drive_a: assert property ($fell(cas_n) && !ras_n && !wr_n |-> dq_oe)
    else $error("early write without data");
  late_oe_a: assert property ($fell(wr_n) && !cas_n |-> oe_n && $past(oe_n))
    else $error("late write with output enable low");
  hiz_drive_a: assert property ($rose(dq_oe) && !cas_n && !$past(cas_n)
    |-> $past(oe_n) && oe_n ##1 oe_n)
    else $error("data driven before outputs open");
  // loose bound: a due refresh may wait behind one transfer
  ref_gap_a: assert property (mem_ready |-> gap_r <= 2 * REF_INTERVAL)
    else $error("refresh interval overrun");
  cover property (row_fall && !cas_n);
  cover property (row_fall && !wr_n);
  cover property ($fell(wr_n) && !cas_n);
  cover property (req_valid && req_ready);
  cover property (row_fall && !cas_n && !wr_n);
endmodule : wdc_ctrl_checker
bind wdc_ctrl wdc_ctrl_checker #(.WAKE_CYCLES(WAKE_CYCLES),
  .REF_INTERVAL(REF_INTERVAL)) chk (.clk, .nrst, .req_valid, .req_ready,
  .mem_ready, .ras_n, .cas_n, .lower_byte_write_strobe_n,
  .upper_byte_write_strobe_n, .oe_n, .dq_oe);

//--- wdc_dram_model.sv
`timescale 1ns/1ns
module wdc_dram_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic oe_n,
  input wire logic [9:0] addr,
  input wire logic dq_oe,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  output int ref_cnt,
  output int err_cnt
);
  initial begin
    ref_cnt = 0;
    err_cnt = 0;
  end
  logic [15:0] mem [0:255];
  logic [15:0] mask = '1;
  logic [15:0] q = '0;
  logic [15:0] last = '0;
  logic [9:0] row = '0;
  logic rd = 1'b0;
  logic lo_n, hi_n, drv;
  assign lo_n = lower_byte_write_strobe_n;
  assign hi_n = upper_byte_write_strobe_n;
  // ---------------------------------------------------------------
  // strobe decode, 1 ns late so both byte strobes have settled
  // ---------------------------------------------------------------
  task automatic wr(input logic [9:0] col);
    logic [15:0] m;
    m = mask & {{8{~hi_n}}, {8{~lo_n}}};
    mem[{row[3:0], col[3:0]}] = (mem[{row[3:0], col[3:0]}] & ~m) | (dq_in & m);
  endtask : wr
  always @(negedge ras_n) begin
    #1;
    if (!cas_n) ref_cnt++;
    else begin
      if (ref_cnt < 8) err_cnt++;
      row = addr;
      mask = {hi_n ? 8'hff : dq_in[15:8], lo_n ? 8'hff : dq_in[7:0]};
    end
  end
  always @(posedge ras_n) rd = 1'b0;
  always @(negedge cas_n) begin
    #1;
    if (!ras_n) begin
      rd = lo_n & hi_n;
      q = mem[{row[3:0], addr[3:0]}];
      if (!rd) wr(addr);
    end
  end
  always @(negedge lo_n or negedge hi_n) begin
    #1;
    if (!cas_n && !ras_n && rd) begin
      rd = 1'b0;
      wr(addr);
    end
  end
  assign drv = !cas_n && !oe_n && rd;
  // no pull on dq: a released bus shows the inverse, not a held value
  assign dq_in = dq_oe ? dq_out : (drv ? q : ~last);
  always @(dq_oe, dq_out, drv, q) begin
    if (dq_oe && drv) err_cnt++;
    if (dq_oe) last = dq_out;
    else if (drv) last = q;
  end
endmodule : wdc_dram_model

//--- test_wide_dram_cycle_behaviour.sv
`timescale 1ns/1ns
module test_wide_dram_cycle_behaviour;
  import wdc_pkg::*;
  localparam int RI = 200;
  localparam logic [19:0] A0 = 20'h00c05;
  localparam logic [19:0] A1 = 20'h0100a;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_masked = 1'b0;
  wdc_op_t req_op = WDC_OP_READ;
  logic [19:0] req_addr = '0;
  logic [1:0] req_bytes = '0;
  logic [15:0] req_mask = '0;
  logic [15:0] req_wdata = '0;
  logic req_ready, rsp_valid, mem_ready, ras_n, cas_n, oe_n, dq_oe;
  logic lower_byte_write_strobe_n, upper_byte_write_strobe_n;
  logic [15:0] rsp_rdata, dq_out, dq_in, rd;
  logic [9:0] addr;
  int ref_cnt, mdl_err;
  int error_cnt = 0;
  int checks = 0;
  always #5 clk = ~clk;
  wdc_ctrl #(.WAKE_CYCLES(20), .REF_INTERVAL(RI)) uut (.clk, .nrst,
    .req_valid, .req_ready, .req_op, .req_addr, .req_bytes, .req_masked,
    .req_mask, .req_wdata, .rsp_valid, .rsp_rdata, .mem_ready, .ras_n,
    .cas_n, .lower_byte_write_strobe_n, .upper_byte_write_strobe_n, .oe_n,
    .addr, .dq_out, .dq_oe, .dq_in);
  wdc_dram_model mdl (.ras_n, .cas_n, .lower_byte_write_strobe_n,
    .upper_byte_write_strobe_n, .oe_n, .addr, .dq_oe, .dq_out, .dq_in,
    .ref_cnt, .err_cnt(mdl_err));
  // ---------------------------------------------------------------
  // compare, finish and request tasks
  // ---------------------------------------------------------------
  task automatic chk16(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk16
  task automatic chk1(input string n, input logic e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic req(input wdc_op_t op, input logic [19:0] a,
      input logic [1:0] b, input logic m, input logic [15:0] mk, wd);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_bytes = b;
    req_masked = m;
    req_mask = mk;
    req_wdata = wd;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk1("accepted", 1'b1, n < 500);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (op != WDC_OP_EARLY_WR && rsp_valid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk1("answered", 1'b1, n < 60);
    rd = rsp_rdata;
  endtask : req
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_wake;
    int n;
    n = 0;
    while (mem_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk1("mem ready", 1'b1, mem_ready);
    chk1("wake refreshes", 1'b1, ref_cnt >= 8);
    $display("wake test done");
  endtask : t_wake
  task automatic t_bytes;
    req(WDC_OP_EARLY_WR, A0, 2'b11, 1'b0, '0, 16'h0000);
    req(WDC_OP_EARLY_WR, A0, 2'b01, 1'b0, '0, 16'ha5c3);
    req(WDC_OP_EARLY_WR, A0, 2'b10, 1'b0, '0, 16'h7e00);
    req(WDC_OP_READ, A0, 2'b00, 1'b0, '0, '0);
    chk16("byte merge", 16'h7ec3, rd);
    $display("byte test done");
  endtask : t_bytes
  task automatic t_mask;
    req(WDC_OP_EARLY_WR, A1, 2'b11, 1'b0, '0, 16'hffff);
    req(WDC_OP_EARLY_WR, A1, 2'b11, 1'b1, 16'h00ff, 16'h1234);
    req(WDC_OP_READ, A1, 2'b00, 1'b0, '0, '0);
    chk16("masked write", 16'hff34, rd);
    req(WDC_OP_EARLY_WR, A1, 2'b11, 1'b1, 16'hff00, 16'h0000);
    req(WDC_OP_READ, A1, 2'b00, 1'b0, '0, '0);
    chk16("fresh mask", 16'h0034, rd);
    $display("mask test done");
  endtask : t_mask
  task automatic t_rmw;
    req(WDC_OP_RMW, A0, 2'b11, 1'b0, '0, 16'h5a5a);
    chk16("rmw old data", 16'h7ec3, rd);
    req(WDC_OP_READ, A0, 2'b00, 1'b0, '0, '0);
    chk16("rmw new data", 16'h5a5a, rd);
    chk1("bus contention", 1'b1, mdl_err == 0);
    $display("rmw test done");
  endtask : t_rmw
  task automatic t_refresh;
    int r0;
    r0 = ref_cnt;
    repeat (3 * RI) @(posedge clk);
    chk1("refresh rate", 1'b1, ref_cnt - r0 >= 2);
    req(WDC_OP_READ, A1, 2'b00, 1'b0, '0, '0);
    chk16("retained", 16'h0034, rd);
    $display("refresh test done");
  endtask : t_refresh
  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk1("ready in reset", 1'b0, mem_ready);
    nrst = 1'b1;
    t_wake();
    t_bytes();
    t_mask();
    t_rmw();
    t_refresh();
    chk1("model errors", 1'b1, mdl_err == 0);
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("Error watchdog expected done seen timeout");
    stop_test();
  end
endmodule : test_wide_dram_cycle_behaviour
